// ### test_timer_pwm_capture_extcount.sv
// self-checking bench of the timer over Avalon-MM and the timer pin
// assumes tpc_pkg and tpc_pin_src are compiled first
`timescale 1ns/1ns

module test_timer_pwm_capture_extcount;
    typedef struct packed {logic [4:0] a; logic [15:0] w; logic [15:0] e;} tpc_row_type;
    localparam tpc_row_type ROWS [5] = '{'{5'h00, 16'h003D, 16'h003D},
        '{5'h08, 16'h1234, 16'h1234}, '{5'h10, 16'h00AB, 16'h00AB},
        '{5'h02, 16'hFFFF, 16'h0000}, '{5'h1C, 16'h5555, 16'h0000}};
    logic        core_clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdv, rdBus, w1, p1;
    logic        wq, pinOut, pinOe, ilf, ovf, srcPin, srcEn = 1'b0, pinWire;
    logic [7:0]  loLen = 8'h06;
    int          mismatches = 0, n_checks = 0, cyc = 0, hi;
    assign pinWire = pinOe ? pinOut : srcPin;
    tpc_timer DUT (.core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'h3), .avs_readdata(rdBus),
        .avs_waitrequest(wq), .timerPinIn(pinWire), .timerPinOut(pinOut),
        .timerPinOe(pinOe), .interruptLatchFlag(ilf), .overflowFlag(ovf));
    tpc_pin_src SRC (.core_clk(core_clk), .srcEn(srcEn), .loLen(loLen), .hiLen(8'h04),
        .srcPin(srcPin));
    initial forever #5 core_clk = !core_clk;
    task automatic final_report;
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %0t %h %h", $time, g, e);
        end
    endtask
    task automatic bw(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        adr <= a;
        wdat <= {16'h0000, d};
        wr <= 1'b1;
        do @(posedge core_clk); while (wq !== 1'b0);
        wr <= 1'b0;
    endtask
    task automatic br(input logic [4:0] a, output logic [31:0] d);
        @(posedge core_clk);
        adr <= a;
        rd <= 1'b1;
        do @(posedge core_clk); while (wq !== 1'b0);
        d = rdBus;
        rd <= 1'b0;
    endtask
    task automatic cfg(input logic [15:0] c, input logic [15:0] p, input logic [15:0] w);
        bw(tpc_pkg::OFS_CFG, c);
        bw(tpc_pkg::OFS_PRDH, 16'h0000);
        bw(tpc_pkg::OFS_PRDL, p);
        bw(tpc_pkg::OFS_WHR, 16'h0000);
        bw(tpc_pkg::OFS_WLR, w);
        bw(tpc_pkg::OFS_STAT, 16'h0100);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    initial begin
        wait_cyc(16);
        rst <= 1'b0;
        // --------------------------------------------------------------
        // reset values, then the register table
        // --------------------------------------------------------------
        br(tpc_pkg::OFS_STAT, rdv);
        chk(rdv, 32'h0);
        chk(32'({ilf, ovf, pinOe, pinOut}), 32'h0);
        foreach (ROWS[i]) begin
            bw(ROWS[i].a, ROWS[i].w);
            br(ROWS[i].a, rdv);
            chk(rdv, {16'h0000, ROWS[i].e});
        end
        cfg(16'h001D, 16'h0002, 16'h0001);
        wait_cyc(10);
        chk(32'({pinOe, ilf}), 32'h3);
        for (int i = 0; i < 6; i++) begin
            hi = pinWire;
            @(posedge core_clk);
            chk(32'(pinWire), 32'(!hi));
        end
        bw(tpc_pkg::OFS_STAT, 16'h0201);
        wait_cyc(3);
        chk(32'(pinWire), 32'h0);
        bw(tpc_pkg::OFS_STAT, 16'h0001);
        wait_cyc(1);
        chk(32'(ilf), 32'h0);
        cfg(16'h001D, 16'h0002, 16'h0000);
        wait_cyc(5);
        chk(32'({ilf, ovf}), 32'h3);
        bw(tpc_pkg::OFS_STAT, 16'h0011);
        // single active-high pulse: period word only has to pass the check
        cfg(16'h0015, 16'h0009, 16'h0005);
        hi = 0;
        for (int i = 0; i < 60; i++) begin
            @(posedge core_clk);
            if (pinWire === 1'b1) hi++;
        end
        chk(32'(hi), 32'h5);
        br(tpc_pkg::OFS_STAT, rdv);
        chk(rdv & 32'h301, 32'h1);
        bw(tpc_pkg::OFS_STAT, 16'h0001);
        // capture: low phase leads under clear polarity; two idle slots first
        bw(tpc_pkg::OFS_CFG, 16'h0012);
        wait_cyc(2);
        bw(tpc_pkg::OFS_STAT, 16'h0100);
        wait_cyc(2);
        br(tpc_pkg::OFS_CNTL, rdv);
        chk(rdv, 32'h1);
        srcEn <= 1'b1;
        for (int i = 0; i < 200 && ilf !== 1'b1; i++) @(posedge core_clk);
        br(tpc_pkg::OFS_PRDL, rdv);
        chk(rdv, 32'h0);
        br(tpc_pkg::OFS_WLR, w1);
        chk(w1, 32'h6);
        wait_cyc(30);
        br(tpc_pkg::OFS_PRDL, p1);
        chk(p1 - w1, 32'h4);
        loLen <= 8'h09;
        wait_cyc(40);
        br(tpc_pkg::OFS_WLR, rdv);
        chk(rdv, w1);
        br(tpc_pkg::OFS_PRDL, rdv);
        chk(rdv, p1 + 32'h3);
        bw(tpc_pkg::OFS_STAT, 16'h0001);
        wait_cyc(30);
        br(tpc_pkg::OFS_WLR, rdv);
        chk(rdv, w1 + 32'h3);
        bw(tpc_pkg::OFS_STAT, 16'h0201);
        srcEn <= 1'b0;
        loLen <= 8'h0A;
        // edge counting: bits that have no effect are set on purpose
        cfg(16'h003F, 16'h0003, 16'h0000);
        srcEn <= 1'b1;
        repeat (2) @(posedge srcPin);
        wait_cyc(6);
        br(tpc_pkg::OFS_CNTL, rdv);
        chk(rdv, 32'hFFFD);
        br(tpc_pkg::OFS_CNTH, rdv);
        chk(32'({rdv[15:0], ilf}), 32'h1FFFE);
        @(posedge srcPin);
        wait_cyc(6);
        chk(32'({ilf, ovf}), 32'h2);
        @(posedge srcPin);
        wait_cyc(6);
        br(tpc_pkg::OFS_CNTL, rdv);
        chk(rdv, 32'hFFFC);
        final_report;
    end
endmodule

// ### tpc_pin_src.sv
// waveform source that stands on the timer pin when the timer reads it
// assumes the bench merges its level with the timer's own drive
`timescale 1ns/1ns

module tpc_pin_src (
    input  wire logic       core_clk,
    input  wire logic       srcEn,
    input  wire logic [7:0] loLen,
    input  wire logic [7:0] hiLen,
    output logic            srcPin
);
    logic [7:0] left;
    initial begin
        srcPin = 1'b1;
        left   = 8'h00;
    end
    // idle high, so the first change after start is a falling edge
    always @(posedge core_clk) begin
        if (!srcEn) begin
            srcPin <= 1'b1;
            left   <= 8'h00;
        end else if (left == 8'h00) begin
            srcPin <= !srcPin;
            left   <= (srcPin ? loLen : hiLen) - 8'h01;
        end else begin
            left <= left - 8'h01;
        end
    end
endmodule

// ### tpc_pkg.sv
// constants, state record and field layout of the 32-bit timer block
// assumes a 16-bit register view reached over a 32-bit Avalon-MM slave
//
// Functional notes
// R1: period-high, period-low, width-high writes wait for width-low write, used at next reload.
// R2: output mode reloads the counter at width expiry and at period expiry.
// R3: periodic output with interrupts enabled latches the flag every period end.
// R4: period 2, width 1 toggles the pin every clock, 50% duty.
// R5: period-count select clear in output mode gives one pulse, period ignored except by the start check.
// R6: end of single pulse latches the flag if interrupts are enabled and stops the timer itself.
// R7: software should choose active-high polarity for single pulses.
// R8: mode 10 is width capture; pin input, period and width read-only.
// R9: capture enable presets counter to one, held until first leading edge.
// R10: trailing edge copies the 32-bit counter into width words, counting on.
// R11: leading edge copies counter to period words and presets counter to one.
// R12: polarity clear means falling leads; set means rising leads.
// R13: capture latches flag on period capture if select set, else on width.
// R14: period words read zero before any period is measured.
// R15: with interrupts enabled first width holds until latch cleared; period updates.
// R16: counter all-ones in capture stops timer, sets overflow, latches flag if enabled.
// R17: software waits two instruction slots between capture mode and enable.
// R18: mode 11 counts rising pin edges, possibly asynchronous.
// R19: first edge loads all-ones minus period, then increments; top latches, next reloads.
// R20: external count ignores select bits, never sets overflow, ignores width.
// R21: external count keeps counting pin edges and can wake the processor.
// R22: width-low rewrite during a pulse gives exactly one wrong-length period.
// R23: mode 01 drives the pin; start loads all-ones minus width, counts to top.
// R24: bad width or period at enable refuses start, sets overflow and latch.
// R25: output mode pin low while disabled; running level follows polarity.
// R26: pin edges pass a two-stage synchronizer before edge detection.
// R27: clearing the latch releases held width words in capture mode.

package tpc_pkg;
    localparam logic [4:0] OFS_CFG  = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h04;
    localparam logic [4:0] OFS_PRDH = 5'h08;
    localparam logic [4:0] OFS_PRDL = 5'h0C;
    localparam logic [4:0] OFS_WHR  = 5'h10;
    localparam logic [4:0] OFS_WLR  = 5'h14;
    localparam logic [4:0] OFS_CNTH = 5'h18;
    localparam logic [4:0] OFS_CNTL = 5'h1C;

    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_POL_BIT  = 2;
    localparam int CFG_PER_BIT  = 3;
    localparam int CFG_IRQ_BIT  = 4;
    localparam int CFG_INS_BIT  = 5;
    localparam int STAT_IL_BIT  = 0;
    localparam int STAT_OVF_BIT = 4;
    localparam int STAT_EN_BIT  = 8;
    localparam int STAT_DIS_BIT = 9;

    localparam logic [1:0]  MODE_OFF   = 2'h0;
    localparam logic [1:0]  MODE_OUT   = 2'h1;
    localparam logic [1:0]  MODE_CAP   = 2'h2;
    localparam logic [1:0]  MODE_EXT   = 2'h3;
    localparam logic [31:0] CNT_TOP    = 32'hFFFFFFFE;
    localparam logic [31:0] CNT_ALL    = 32'hFFFFFFFF;
    localparam logic [31:0] CNT_PRESET = 32'h00000001;
    localparam logic [15:0] REG_RESET  = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_CHECK, ST_RUN} tpc_state_type;

    typedef struct packed {
        tpc_state_type state;
        logic          ack;
        logic [15:0]   rdata;
        logic [1:0]    mode;
        logic          pol;
        logic          perCnt;
        logic          irqEna;
        logic          inSel;
        logic [15:0]   prdH;
        logic [15:0]   prdL;
        logic [15:0]   whr;
        logic [15:0]   wlr;
        logic [31:0]   actPer;
        logic [31:0]   actWid;
        logic          updPend;
        logic [31:0]   cnt;
        logic          widPhase;
        logic          waiting;
        logic          widHeld;
        logic          irq;
        logic          ovf;
        logic          sync1;
        logic          sync2;
        logic          pinPrev;
        logic          pinOut;
    } tpc_regs_type;
endpackage

// ### tpc_timer.sv
// timer with waveform output, width capture and external edge counting
// assumes an Avalon-MM master on core_clk and an asynchronous timer pin
`timescale 1ns/1ns

module tpc_timer (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        timerPinIn,
    output logic             timerPinOut,
    output logic             timerPinOe,
    output logic             interruptLatchFlag,
    output logic             overflowFlag
);
    tpc_pkg::tpc_regs_type s;
    tpc_pkg::tpc_regs_type n;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                               input logic [15:0] wd,
                                               input logic [1:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic badPair(input logic [31:0] per, input logic [31:0] wid);
        return (wid == 32'h00000000) || (per <= wid);
    endfunction

    logic        req;
    logic        wr;
    logic        rise;
    logic        fall;
    logic        lead;
    logic        trail;
    logic        ilSet;
    logic        ilClr;
    logic        ovfSet;
    logic        ovfClr;
    logic        heldSet;
    logic        heldClr;
    logic [15:0] wd;
    logic [31:0] perUse;
    logic [31:0] widUse;
    logic [31:0] extNew;
    logic [15:0] rmux;

    assign req                = avs_read | avs_write;
    assign avs_waitrequest    = req & ~s.ack;
    assign avs_readdata       = {16'h0000, s.rdata};
    assign timerPinOut        = s.pinOut;
    assign timerPinOe         = (s.mode == tpc_pkg::MODE_OUT);
    assign interruptLatchFlag = s.irq;
    assign overflowFlag       = s.ovf;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n       = s;
        wd      = avs_writedata[15:0];
        wr      = s.ack & avs_write;
        ilSet   = 1'b0;
        ovfSet  = 1'b0;
        heldSet = 1'b0;
        heldClr = 1'b0;
        ilClr   = wr && (avs_address == tpc_pkg::OFS_STAT) && avs_byteenable[0]
                  && wd[tpc_pkg::STAT_IL_BIT];
        ovfClr  = wr && (avs_address == tpc_pkg::OFS_STAT) && avs_byteenable[0]
                  && wd[tpc_pkg::STAT_OVF_BIT];
        // one wait state: answer on the edge after the request is seen
        n.ack   = req & ~s.ack;

        // stage one feeds stage two only
        n.sync1   = timerPinIn; // R26
        n.sync2   = s.sync1;
        n.pinPrev = s.sync2;
        rise      = s.sync2 & ~s.pinPrev;
        fall      = ~s.sync2 & s.pinPrev;
        lead      = s.pol ? rise : fall; // R12
        trail     = s.pol ? fall : rise; // R12

        // new buffered values are only taken at a reload
        perUse = s.updPend ? {s.prdH, s.prdL} : s.actPer; // R1
        widUse = s.updPend ? {s.whr, s.wlr} : s.actWid; // R1
        extNew = 32'h00000000;

        case (avs_address)
            tpc_pkg::OFS_CFG:  rmux = {10'h000, s.inSel, s.irqEna, s.perCnt, s.pol, s.mode};
            tpc_pkg::OFS_STAT: rmux = {6'h00, (s.state != tpc_pkg::ST_IDLE),
                                       (s.state != tpc_pkg::ST_IDLE), 3'h0, s.ovf, 3'h0, s.irq};
            tpc_pkg::OFS_PRDH: rmux = s.prdH;
            tpc_pkg::OFS_PRDL: rmux = s.prdL;
            tpc_pkg::OFS_WHR:  rmux = s.whr;
            tpc_pkg::OFS_WLR:  rmux = s.wlr;
            tpc_pkg::OFS_CNTH: rmux = s.cnt[31:16];
            tpc_pkg::OFS_CNTL: rmux = s.cnt[15:0];
            default:           rmux = 16'h0000;
        endcase
        if (req & ~s.ack) begin
            n.rdata = rmux;
        end

        // --------------------------------------------------------
        // counter engine
        // --------------------------------------------------------
        case (s.state)
            tpc_pkg::ST_IDLE: begin
                n.state = tpc_pkg::ST_IDLE;
            end
            tpc_pkg::ST_ARM: begin
                n.state = tpc_pkg::ST_CHECK;
            end
            tpc_pkg::ST_CHECK: begin
                case (s.mode)
                    tpc_pkg::MODE_OUT: begin
                        if (badPair({s.prdH, s.prdL}, {s.whr, s.wlr})) begin
                            ilSet   = 1'b1; // R24
                            ovfSet  = 1'b1; // R24
                            n.state = tpc_pkg::ST_IDLE;
                        end else begin
                            n.actPer   = {s.prdH, s.prdL};
                            n.actWid   = {s.whr, s.wlr};
                            n.updPend  = 1'b0;
                            n.cnt      = tpc_pkg::CNT_ALL - {s.whr, s.wlr}; // R23
                            n.widPhase = 1'b1;
                            n.state    = tpc_pkg::ST_RUN;
                        end
                    end
                    tpc_pkg::MODE_CAP: begin
                        n.cnt     = tpc_pkg::CNT_PRESET; // R9
                        n.waiting = 1'b1; // R9
                        n.prdH    = 16'h0000; // R14
                        n.prdL    = 16'h0000; // R14
                        heldClr   = 1'b1;
                        n.state   = tpc_pkg::ST_RUN;
                    end
                    tpc_pkg::MODE_EXT: begin
                        n.waiting = 1'b1;
                        n.state   = tpc_pkg::ST_RUN;
                    end
                    default: begin
                        n.state = tpc_pkg::ST_IDLE;
                    end
                endcase
            end
            tpc_pkg::ST_RUN: begin
                case (s.mode)
                    tpc_pkg::MODE_OUT: begin
                        if (s.cnt == tpc_pkg::CNT_TOP) begin
                            if (s.widPhase && !s.perCnt) begin
                                // single pulse ends here, period not used beyond the start check
                                ilSet   = s.irqEna; // R5 R6
                                n.state = tpc_pkg::ST_IDLE; // R6
                            end else if (s.widPhase) begin
                                // width-end reload: a fresh width here skews one period
                                n.actPer   = perUse; // R22
                                n.actWid   = widUse;
                                n.updPend  = 1'b0;
                                n.cnt      = tpc_pkg::CNT_ALL - (perUse - widUse); // R2
                                n.widPhase = 1'b0;
                            end else begin
                                n.actPer   = perUse;
                                n.actWid   = widUse;
                                n.updPend  = 1'b0;
                                n.cnt      = tpc_pkg::CNT_ALL - widUse; // R2 R4
                                n.widPhase = 1'b1;
                                ilSet      = s.irqEna; // R3
                            end
                        end else begin
                            n.cnt = s.cnt + 32'h00000001; // R23
                        end
                    end
                    tpc_pkg::MODE_CAP: begin
                        if (s.waiting) begin
                            n.waiting = ~lead; // R9
                        end else if (s.cnt == tpc_pkg::CNT_ALL) begin
                            n.state = tpc_pkg::ST_IDLE; // R16
                            ovfSet  = 1'b1; // R16
                            ilSet   = s.irqEna; // R16
                        end else if (lead) begin
                            n.prdH = s.cnt[31:16]; // R11
                            n.prdL = s.cnt[15:0]; // R11
                            n.cnt  = tpc_pkg::CNT_PRESET; // R11
                            ilSet  = s.irqEna & s.perCnt; // R13
                        end else begin
                            n.cnt = s.cnt + 32'h00000001;
                            if (trail && !s.widHeld) begin
                                n.whr   = s.cnt[31:16]; // R10 R15
                                n.wlr   = s.cnt[15:0]; // R10
                                heldSet = s.irqEna; // R15
                                ilSet   = s.irqEna & ~s.perCnt; // R13
                            end
                        end
                    end
                    tpc_pkg::MODE_EXT: begin
                        // pin edges are the count source; width and select bits unused
                        if (rise) begin // R18
                            if (s.waiting || (s.cnt == tpc_pkg::CNT_TOP)) begin
                                extNew = tpc_pkg::CNT_ALL - {s.prdH, s.prdL}; // R19
                            end else begin
                                extNew = s.cnt + 32'h00000001; // R19 R21
                            end
                            n.cnt     = extNew;
                            n.waiting = 1'b0;
                            ilSet     = s.irqEna && (extNew == tpc_pkg::CNT_TOP); // R19 R20
                        end
                    end
                    default: begin
                        n.state = tpc_pkg::ST_IDLE;
                    end
                endcase
            end
            default: begin
                n.state = tpc_pkg::ST_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // register writes
        // --------------------------------------------------------
        if (wr) begin
            case (avs_address)
                tpc_pkg::OFS_CFG: begin
                    if (avs_byteenable[0]) begin
                        n.mode   = wd[tpc_pkg::CFG_MODE_LSB +: 2];
                        n.pol    = wd[tpc_pkg::CFG_POL_BIT];
                        n.perCnt = wd[tpc_pkg::CFG_PER_BIT];
                        n.irqEna = wd[tpc_pkg::CFG_IRQ_BIT];
                        n.inSel  = wd[tpc_pkg::CFG_INS_BIT];
                    end
                end
                tpc_pkg::OFS_STAT: begin
                    if (avs_byteenable[1] && wd[tpc_pkg::STAT_DIS_BIT]) begin
                        n.state = tpc_pkg::ST_IDLE;
                    end else if (avs_byteenable[1] && wd[tpc_pkg::STAT_EN_BIT]
                                 && (s.state == tpc_pkg::ST_IDLE)) begin
                        n.state = tpc_pkg::ST_ARM;
                    end
                end
                tpc_pkg::OFS_PRDH: begin
                    if (s.mode != tpc_pkg::MODE_CAP) begin // R8
                        n.prdH = mergeBytes(s.prdH, wd, avs_byteenable[1:0]);
                    end
                end
                tpc_pkg::OFS_PRDL: begin
                    if (s.mode != tpc_pkg::MODE_CAP) begin // R8
                        n.prdL = mergeBytes(s.prdL, wd, avs_byteenable[1:0]);
                    end
                end
                tpc_pkg::OFS_WHR: begin
                    if (s.mode != tpc_pkg::MODE_CAP) begin // R8
                        n.whr = mergeBytes(s.whr, wd, avs_byteenable[1:0]);
                    end
                end
                tpc_pkg::OFS_WLR: begin
                    if (s.mode != tpc_pkg::MODE_CAP) begin // R8
                        n.wlr     = mergeBytes(s.wlr, wd, avs_byteenable[1:0]);
                        n.updPend = 1'b1; // R1
                    end
                end
                default: begin
                    n.mode = s.mode;
                end
            endcase
        end

        // hardware set wins over a software clear in the same cycle
        n.irq     = (s.irq & ~ilClr) | ilSet;
        n.ovf     = (s.ovf & ~ovfClr) | ovfSet;
        n.widHeld = (s.widHeld & ~ilClr & ~heldClr) | heldSet; // R27

        // idle pin is low whatever the polarity
        if ((n.state == tpc_pkg::ST_RUN) && (n.mode == tpc_pkg::MODE_OUT)) begin
            n.pinOut = n.widPhase ? n.pol : ~n.pol; // R25
        end else begin
            n.pinOut = 1'b0; // R25
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    pin_low_idle_a: assert property ( // R25
        (s.state != tpc_pkg::ST_RUN) |-> !timerPinOut)
        else $error("pin not low while timer idle");
    pwm_reload_a: assert property ( // R2
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_OUT) && s.perCnt
        && (s.cnt == tpc_pkg::CNT_TOP)
        |=> (s.cnt != tpc_pkg::CNT_ALL) && (s.widPhase != $past(s.widPhase)))
        else $error("output counter not reloaded at top");
    toggle_max_a: assert property ( // R4
        (s.state == tpc_pkg::ST_RUN) && ($past(s.state) == tpc_pkg::ST_RUN)
        && (s.mode == tpc_pkg::MODE_OUT) && s.perCnt && !wr
        && (s.actPer == 32'h00000002) && (s.actWid == 32'h00000001) && !s.updPend
        |=> (timerPinOut != $past(timerPinOut)))
        else $error("pin does not toggle at period two width one");
    period_irq_a: assert property ( // R3
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_OUT) && s.perCnt && s.irqEna
        && !s.widPhase && (s.cnt == tpc_pkg::CNT_TOP) |=> s.irq)
        else $error("period end did not latch flag");
    single_stop_a: assert property ( // R6
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_OUT) && !s.perCnt && s.widPhase
        && (s.cnt == tpc_pkg::CNT_TOP) && !wr
        |=> (s.state == tpc_pkg::ST_IDLE) && (s.irq == s.irqEna || s.irq))
        else $error("single pulse did not stop");
    bad_start_a: assert property ( // R24
        (s.state == tpc_pkg::ST_CHECK) && (s.mode == tpc_pkg::MODE_OUT)
        && badPair({s.prdH, s.prdL}, {s.whr, s.wlr})
        |=> s.ovf && s.irq && (s.state != tpc_pkg::ST_RUN))
        else $error("bad start not flagged");
    cap_preset_a: assert property ( // R9
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_CAP) && s.waiting
        |-> (s.cnt == tpc_pkg::CNT_PRESET))
        else $error("capture counter not held at one");
    cap_ovf_a: assert property ( // R16
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_CAP) && !s.waiting
        && (s.cnt == tpc_pkg::CNT_ALL) |=> (s.state == tpc_pkg::ST_IDLE) && s.ovf)
        else $error("capture overflow not handled");
    ext_noovf_a: assert property ( // R20
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_EXT) && !s.ovf |=> !s.ovf)
        else $error("overflow set in external count mode");
    bus_wait_a: assert property (
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

    // a trailing edge captures the width unless held; a held width must not move
    cap_width_a: assert property ( // R10 R13
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_CAP) && !s.waiting
        && (s.cnt != tpc_pkg::CNT_ALL) && !lead && trail && !s.widHeld
        && s.irqEna && !s.perCnt
        |=> s.irq && ({s.whr, s.wlr} == $past(s.cnt)))
        else $error("trailing edge did not capture width");
    width_hold_a: assert property ( // R15
        (s.mode == tpc_pkg::MODE_CAP) && s.widHeld
        |=> $stable({s.whr, s.wlr}))
        else $error("held width words changed");
    ext_reload_a: assert property ( // R19
        (s.state == tpc_pkg::ST_RUN) && (s.mode == tpc_pkg::MODE_EXT) && rise
        && !s.waiting && (s.cnt == tpc_pkg::CNT_TOP)
        |=> (s.cnt == tpc_pkg::CNT_ALL - $past({s.prdH, s.prdL})))
        else $error("edge count not reloaded after top");

    pwm_run_c:    cover property ((s.mode == tpc_pkg::MODE_OUT) && s.perCnt && ilSet);
    single_c:     cover property ((s.mode == tpc_pkg::MODE_OUT) && !s.perCnt && ilSet);
    cap_period_c: cover property ((s.mode == tpc_pkg::MODE_CAP) && lead && !s.waiting);
    ext_top_c:    cover property ((s.mode == tpc_pkg::MODE_EXT) && (extNew == tpc_pkg::CNT_TOP));
    hold_c:       cover property ((s.mode == tpc_pkg::MODE_CAP) && trail && s.widHeld);
endmodule
